/* File: verilog/tplat_pkg.sv */
// Package for the probe position capture block.
// Assumes one drive clock; object indices are those of the fieldbus map.
package tplat_pkg;

  // Object indices of the read-only process data objects
  localparam logic [15:0] TPLAT_IDX_STATUS    = 16'h60b9;
  localparam logic [15:0] TPLAT_IDX_ONE_RISE  = 16'h60ba;
  localparam logic [15:0] TPLAT_IDX_ONE_FALL  = 16'h60bb;
  localparam logic [15:0] TPLAT_IDX_TWO_RISE  = 16'h60bc;
  localparam logic [15:0] TPLAT_IDX_TWO_FALL  = 16'h60bd;

  // Status word field positions
  localparam int TPLAT_BIT_ONE_EN   = 0;
  localparam int TPLAT_BIT_ONE_RISE = 1;
  localparam int TPLAT_BIT_ONE_FALL = 2;
  localparam int TPLAT_BIT_TWO_EN   = 8;
  localparam int TPLAT_BIT_TWO_RISE = 9;
  localparam int TPLAT_BIT_TWO_FALL = 10;

  // Reset values
  localparam logic [15:0] TPLAT_STATUS_RST = 16'h0000;
  localparam logic [31:0] TPLAT_POS_RST    = 32'h0000_0000;
  localparam logic [31:0] TPLAT_DATA_RST   = 32'h0000_0000;

  // Per-probe control, as carried from the probe control word
  typedef struct packed {
    logic enable;
    logic rise_en;
    logic fall_en;
  } tplat_probe_ctl_t;

  // Per-probe captured state
  typedef struct packed {
    logic        rise_seen;
    logic        fall_seen;
    logic [31:0] rise_pos;
    logic [31:0] fall_pos;
  } tplat_probe_cap_t;

endpackage

/* File: verilog/tplat_top.sv */
// Probe position capture: latches axis position on probe edges and
// builds the probe status word plus four captured position objects.
// Assumes probe inputs synchronous to mclk and a position counter input.
//
// Behaviour
// R1: Probe status is a 16-bit read-only word in cyclic transmit data.
// R2: Status bit 0 shows whether probe one is enabled.
// R3: Status bit 1 set once probe one rising edge captured.
// R4: Status bit 2 set once probe one falling edge captured.
// R5: Status bit 8 shows whether probe two is enabled.
// R6: Status bit 9 set once probe two rising edge captured.
// R7: Status bit 10 set once probe two falling edge captured.
// R8: Probe one rising edge stores signed 32-bit position, read-only.
// R9: Probe one falling edge stores position in separate read-only object.
// R10: Probe two rising edge stores position in its own object.
// R11: Probe two falling edge stores position in its own object.
// R12: Master enables rising capture via edge-action bit; probe two bit 12.
// R13: Master enables falling capture via edge-action bit; probe two bit 13.
// R14: Status bits 3 to 7 and 11 to 15 always read zero.
// R15: A captured position holds until next qualifying edge overwrites it.
`timescale 1ns/1ps

module tplat_top
  import tplat_pkg::*;
(
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // Probe control, decoded from the probe control word by the master
  input  wire tplat_pkg::tplat_probe_ctl_t probe_one_ctl,
  input  wire tplat_pkg::tplat_probe_ctl_t probe_two_ctl,
  // Probe inputs and axis position
  input  wire logic                       probe_one_in,
  input  wire logic                       probe_two_in,
  input  wire logic signed [31:0]         axis_position,
  // Object read port
  input  wire logic [15:0]                obj_index,
  output logic [31:0]                     obj_data,
  output logic                            obj_valid,
  // Cyclic transmit data
  output logic [15:0]                     probe_status_word,
  output logic [31:0]                     probe_one_rise_position,
  output logic [31:0]                     probe_one_fall_position,
  output logic [31:0]                     probe_two_rise_position,
  output logic [31:0]                     probe_two_fall_position
);
  import tplat_pkg::*;

  // Edge memory per probe
  logic             one_prev_ff;
  logic             two_prev_ff;
  // Captured flags and positions per probe
  tplat_probe_cap_t one_cap_ff;
  tplat_probe_cap_t two_cap_ff;
  tplat_probe_cap_t nxt_one_cap;
  tplat_probe_cap_t nxt_two_cap;
  // Qualified edges, one per probe and polarity
  logic             one_rise_hit;
  logic             one_fall_hit;
  logic             two_rise_hit;
  logic             two_fall_hit;
  // Status word
  logic [15:0]      status_ff;
  logic [15:0]      nxt_status;
  // Object read port
  logic             sel_status;
  logic             sel_one_rise;
  logic             sel_one_fall;
  logic             sel_two_rise;
  logic             sel_two_fall;
  logic [31:0]      obj_data_ff;
  logic [31:0]      nxt_obj_data;
  logic             obj_valid_ff;
  logic             nxt_obj_valid;

  // Level went from low to high between two samples
  function automatic logic rise_seen_now(
    input logic prev,
    input logic now
  );
    return !prev && now;
  endfunction

  // Level went from high to low between two samples
  function automatic logic fall_seen_now(
    input logic prev,
    input logic now
  );
    return prev && !now;
  endfunction

  // An edge only counts while its probe and that polarity are armed
  function automatic logic qualify(
    input logic enable,
    input logic pol_en,
    input logic seen
  );
    return enable && pol_en && seen;
  endfunction

  // One capture step; a disabled probe clears its latch flags, while the
  // stored positions stay so the master can still read the last ones.
  function automatic tplat_probe_cap_t cap_step(
    input tplat_probe_cap_t cur,
    input logic             enable,
    input logic             rise_hit,
    input logic             fall_hit,
    input logic [31:0]      pos
  );
    tplat_probe_cap_t res;
    res = cur;
    if (!enable) begin
      res.rise_seen = 1'b0;
      res.fall_seen = 1'b0;
    end
    if (rise_hit) begin
      res.rise_seen = 1'b1;
      res.rise_pos  = pos;
    end
    if (fall_hit) begin
      res.fall_seen = 1'b1;
      res.fall_pos  = pos;
    end
    return res;
  endfunction

  // Edge qualification; rise and fall of one probe never coincide
  // R8 R12
  assign one_rise_hit = qualify(probe_one_ctl.enable, probe_one_ctl.rise_en,
                                rise_seen_now(one_prev_ff, probe_one_in));
  // R9 R13
  assign one_fall_hit = qualify(probe_one_ctl.enable, probe_one_ctl.fall_en,
                                fall_seen_now(one_prev_ff, probe_one_in));
  // R10 R12
  assign two_rise_hit = qualify(probe_two_ctl.enable, probe_two_ctl.rise_en,
                                rise_seen_now(two_prev_ff, probe_two_in));
  // R11 R13
  assign two_fall_hit = qualify(probe_two_ctl.enable, probe_two_ctl.fall_en,
                                fall_seen_now(two_prev_ff, probe_two_in));

  // R8 R9 R15
  assign nxt_one_cap = cap_step(one_cap_ff, probe_one_ctl.enable,
                                one_rise_hit, one_fall_hit, axis_position);
  // R10 R11 R15
  assign nxt_two_cap = cap_step(two_cap_ff, probe_two_ctl.enable,
                                two_rise_hit, two_fall_hit, axis_position);

  always_comb begin
    nxt_status = 16'h0000; // R14
    nxt_status[TPLAT_BIT_ONE_EN]   = probe_one_ctl.enable;    // R2
    nxt_status[TPLAT_BIT_ONE_RISE] = nxt_one_cap.rise_seen;   // R3
    nxt_status[TPLAT_BIT_ONE_FALL] = nxt_one_cap.fall_seen;   // R4
    nxt_status[TPLAT_BIT_TWO_EN]   = probe_two_ctl.enable;    // R5
    nxt_status[TPLAT_BIT_TWO_RISE] = nxt_two_cap.rise_seen;   // R6
    nxt_status[TPLAT_BIT_TWO_FALL] = nxt_two_cap.fall_seen;   // R7
  end

  // Object decode; unknown indices answer zero with valid low
  assign sel_status    = (obj_index == TPLAT_IDX_STATUS);
  assign sel_one_rise  = (obj_index == TPLAT_IDX_ONE_RISE);
  assign sel_one_fall  = (obj_index == TPLAT_IDX_ONE_FALL);
  assign sel_two_rise  = (obj_index == TPLAT_IDX_TWO_RISE);
  assign sel_two_fall  = (obj_index == TPLAT_IDX_TWO_FALL);
  assign nxt_obj_valid = sel_status | sel_one_rise | sel_one_fall |
                         sel_two_rise | sel_two_fall;
  // A read reflects a capture taken at the same edge
  assign nxt_obj_data  = sel_status   ? {16'h0000, nxt_status} : // R1
                         sel_one_rise ? nxt_one_cap.rise_pos   :
                         sel_one_fall ? nxt_one_cap.fall_pos   :
                         sel_two_rise ? nxt_two_cap.rise_pos   :
                         sel_two_fall ? nxt_two_cap.fall_pos   :
                         TPLAT_DATA_RST;

  // Zero after reset: a probe already high at release reads as a rising
  // edge, so the master should arm capture once the probe is known low.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      one_prev_ff <= 1'b0;
      two_prev_ff <= 1'b0;
    end else begin
      one_prev_ff <= probe_one_in;
      two_prev_ff <= probe_two_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      one_cap_ff <= '{1'b0, 1'b0, TPLAT_POS_RST, TPLAT_POS_RST};
    end else begin
      one_cap_ff <= nxt_one_cap; // R15
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      two_cap_ff <= '{1'b0, 1'b0, TPLAT_POS_RST, TPLAT_POS_RST};
    end else begin
      two_cap_ff <= nxt_two_cap; // R15
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_ff <= TPLAT_STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      obj_data_ff  <= TPLAT_DATA_RST;
      obj_valid_ff <= 1'b0;
    end else begin
      obj_data_ff  <= nxt_obj_data;
      obj_valid_ff <= nxt_obj_valid;
    end
  end

  assign probe_status_word       = status_ff; // R1
  assign probe_one_rise_position = one_cap_ff.rise_pos;
  assign probe_one_fall_position = one_cap_ff.fall_pos;
  assign probe_two_rise_position = two_cap_ff.rise_pos;
  assign probe_two_fall_position = two_cap_ff.fall_pos;
  assign obj_data                = obj_data_ff;
  assign obj_valid               = obj_valid_ff;

endmodule

/* File: dv/tplat_master.sv */
// Master model: decodes the probe control word into per-probe control.
// Assumes the bench sets the word between clock edges.
`timescale 1ns/1ps
module tplat_master
  import tplat_pkg::*;
#(
  parameter int ONE_EN = 0, ONE_RISE = 1, ONE_FALL = 2, TWO_EN = 8
) (
  // Control word in, probe control out
  input  wire logic [15:0]             ctl_word,
  output tplat_pkg::tplat_probe_ctl_t  probe_one_ctl,
  output tplat_pkg::tplat_probe_ctl_t  probe_two_ctl
);
  assign probe_one_ctl = {ctl_word[ONE_EN], ctl_word[ONE_RISE],
                          ctl_word[ONE_FALL]};
  assign probe_two_ctl = {ctl_word[TWO_EN],
                          ctl_word[12], ctl_word[13]};
endmodule

/* File: dv/tplat_top_properties.sv */
// Checker on the probe capture block ports.
// Assumes it is bound to every tplat_top instance.
`timescale 1ns/1ps
module tplat_top_properties
  import tplat_pkg::*;
(
  input wire logic mclk, rst_n, probe_one_in, probe_two_in, obj_valid,
  input wire tplat_pkg::tplat_probe_ctl_t probe_one_ctl, probe_two_ctl,
  input wire logic signed [31:0] axis_position,
  input wire logic [15:0] obj_index, probe_status_word,
  input wire logic [31:0] obj_data, probe_one_rise_position,
    probe_one_fall_position, probe_two_rise_position, probe_two_fall_position
);
  logic p1_ff, p2_ff, r_ff;
  // Own edge memory; edges right after reset are skipped, prev differs
  always_ff @(posedge mclk) begin
    p1_ff <= probe_one_in;
    p2_ff <= probe_two_in;
    r_ff  <= rst_n;
  end
  wire ok  = r_ff & rst_n;
  wire c1  = ok & probe_one_ctl.enable;
  wire c2  = ok & probe_two_ctl.enable;
  wire o_r = c1 & probe_one_ctl.rise_en & probe_one_in & !p1_ff;
  wire o_f = c1 & probe_one_ctl.fall_en & !probe_one_in & p1_ff;
  wire t_r = c2 & probe_two_ctl.rise_en & probe_two_in & !p2_ff;
  wire t_f = c2 & probe_two_ctl.fall_en & !probe_two_in & p2_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_ONE_RISE: assert property (o_r |=> probe_status_word[1] &&
    probe_one_rise_position == $past(axis_position)) else $error("p1 rise");
  AST_ONE_FALL: assert property (o_f |=> probe_status_word[2] &&
    probe_one_fall_position == $past(axis_position)) else $error("p1 fall");
  AST_TWO_RISE: assert property (t_r |=> probe_status_word[9] &&
    probe_two_rise_position == $past(axis_position)) else $error("p2 rise");
  AST_TWO_FALL: assert property (t_f |=> probe_status_word[10] &&
    probe_two_fall_position == $past(axis_position)) else $error("p2 fall");
  AST_EN_BITS: assert property ($past(rst_n) |->
    {probe_status_word[8], probe_status_word[0]} ==
    $past({probe_two_ctl.enable, probe_one_ctl.enable})) else $error("en");
  AST_RSVD: assert property ((probe_status_word & 16'hf8f8) == 0)
    else $error("reserved bits set");
  AST_HOLD: assert property (ok & !o_r |=>
    $stable(probe_one_rise_position)) else $error("position moved");
  AST_CLEAR: assert property (!probe_one_ctl.enable |=>
    probe_status_word[2:1] == 2'b00) else $error("flags not cleared");
  AST_READ: assert property (obj_index == TPLAT_IDX_STATUS |=>
    obj_valid && obj_data == {16'h0, probe_status_word}) else $error("rd");
  cover property (o_r);
  cover property (t_f);
  cover property (obj_valid && obj_index == TPLAT_IDX_STATUS);
endmodule
bind tplat_top tplat_top_properties chk_u (.*);

/* File: dv/tb.sv */
// Bench: captures on both probes, object reads, refused edges.
// Assumes tplat_master decodes the control word.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
  import tplat_pkg::*;
  logic mclk = 0, rst_n = 0, probe_one_in = 0, probe_two_in = 0, obj_valid;
  logic signed [31:0] axis_position = 0;
  logic [15:0] ctl_word = 0, obj_index = 0, probe_status_word;
  logic [31:0] obj_data, probe_one_rise_position, probe_one_fall_position;
  logic [31:0] probe_two_rise_position, probe_two_fall_position;
  tplat_probe_ctl_t probe_one_ctl, probe_two_ctl;
  int n_mismatch = 0, compares = 0;
  tplat_master mst_u (.*);
  tplat_top dut_u (.*);
  initial forever #25 mclk = ~mclk;
  task tick; @(posedge mclk) #2; endtask
  task final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task s_one;
    ctl_word = 16'h0007; tick;
    axis_position = 32'h8000_0001; probe_one_in = 1; tick;
    `CHK(probe_one_rise_position, 32'h8000_0001)
    `CHK(probe_status_word, 16'h0003)
    axis_position = 32'h7fff_fffe; probe_one_in = 0;
    obj_index = TPLAT_IDX_ONE_FALL; tick;
    `CHK(obj_data, 32'h7fff_fffe)
    `CHK(probe_status_word, 16'h0007)
    obj_index = TPLAT_IDX_ONE_RISE;
    tick;
    `CHK(obj_data, 32'h8000_0001)
    `CHK(obj_valid, 1'b1)
  endtask
  task s_two;
    ctl_word = 16'h3100; axis_position = 32'h1234; probe_two_in = 1; tick;
    `CHK(probe_two_rise_position, 32'h1234)
    probe_two_in = 0;
    axis_position = 32'h5678;
    obj_index = TPLAT_IDX_TWO_FALL;
    tick;
    `CHK(obj_data, 32'h5678)
    `CHK(probe_status_word, 16'h0700)
    `CHK(probe_one_fall_position, 32'h7fff_fffe)
    obj_index = TPLAT_IDX_TWO_RISE;
    tick;
    `CHK(obj_data, 32'h1234)
    `CHK(probe_two_fall_position, 32'h5678)
  endtask
  task s_refused;
    ctl_word = 0; tick;
    ctl_word = 16'h0100; axis_position = 5; probe_two_in = 1; tick;
    probe_two_in = 0; obj_index = TPLAT_IDX_STATUS; tick;
    `CHK(obj_data, 32'h0100)
    `CHK(probe_two_rise_position, 32'h1234)
    obj_index = 16'h60be; tick;
    `CHK({obj_valid, obj_data}, 33'h0)
  endtask
  task s_reset;
    rst_n = 0;
    tick;
    tick;
    rst_n = 1;
    `CHK({probe_status_word, probe_one_rise_position}, 48'h0)
    `CHK({probe_two_fall_position, obj_valid}, 33'h0)
  endtask
  initial begin
    repeat (3) tick;
    rst_n = 1;
    `CHK(probe_status_word, 16'h0000)
    s_one;
    s_two;
    s_refused;
    s_reset;
    final_report;
  end
endmodule
